// ---- dtc_timer.sv ----
// Two timer/counters with four modes, register port and interrupt status
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Mode 0: 5-bit prescaler drives high byte
// - Mode 0: low byte upper bits undefined
// - Mode 1: low and high cascade, 16 bits
// - Mode 2: low wraps, reload from high
// - New reload value used at next reload
// - Overflow flag cleared on interrupt service
// - T0 mode 3: low byte uses t0 controls
// - T0 mode 3: high byte uses t1 run/flag
// - T1 mode 3 halts and holds count
// - T1 controls in upper nibble, ctrl 2,3,6,7
// - Gate plus run lets pin enable counting
// - Wrap from all ones sets overflow flag
// - T1 overflow drives serial baud clock
// - Timer source ticks every six clocks
// - Counter source counts sampled falling edges
// - Gated t1 counts while pin high
module dtc_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Interrupt service acknowledges
  input wire logic t0_irq_ack,
  input wire logic t1_irq_ack,
  // External pins
  input wire logic t0_count_pin,
  input wire logic t1_count_pin,
  input wire logic ext_irq0_pin,
  input wire logic ext_irq1_pin,
  // Outputs
  output logic t0_overflow_flag,
  output logic t1_overflow_flag,
  output logic baud_tick,
  output logic irq
);
  logic [7:0] timer_mode_reg_ff;
  logic t0_run_bit_ff, t1_run_bit_ff, t0_ovf_ff, t1_ovf_ff;
  logic [3:0] ext_irq_bits_ff;
  logic [7:0] t0_low_count_ff, t0_high_count_ff, t1_low_count_ff, t1_high_count_ff;
  logic [1:0] irq_stat_ff, irq_mask_ff;
  logic [7:0] reg_rdata_ff;
  logic baud_tick_ff, irq_ff;
  logic [2:0] per_cnt_ff;
  logic [3:0] sync1_ff, sync2_ff;
  logic cnt0_prev_ff, cnt1_prev_ff;
  logic per_tick;
  logic wr_mode, wr_ctrl, wr_t0l, wr_t0h, wr_t1l, wr_t1h;
  // Synchronisers: 0=t0 count, 1=t1 count, 2=irq0 pin, 3=irq1 pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
    end else begin
      sync1_ff <= {ext_irq1_pin, ext_irq0_pin, t1_count_pin, t0_count_pin};
      sync2_ff <= sync1_ff;
    end
  end
  // Peripheral cycle divider
  always_ff @(posedge clk) begin
    if (!rst_n) per_cnt_ff <= 3'h0;
    else if (per_cnt_ff == dtc_pkg::PER_LAST) per_cnt_ff <= 3'h0;
    else per_cnt_ff <= per_cnt_ff + 3'h1;
  end
  assign per_tick = (per_cnt_ff == dtc_pkg::PER_LAST);
  // Count pins sampled once per peripheral cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt0_prev_ff <= 1'b0;
      cnt1_prev_ff <= 1'b0;
    end else if (per_tick) begin
      cnt0_prev_ff <= sync2_ff[0];
      cnt1_prev_ff <= sync2_ff[1];
    end
  end
  logic fall0, fall1;
  assign fall0 = per_tick && cnt0_prev_ff && !sync2_ff[0];
  assign fall1 = per_tick && cnt1_prev_ff && !sync2_ff[1];
  dtc_pkg::dtc_mode_t mode0, mode1;
  assign mode0 = dtc_pkg::dtc_mode_t'({timer_mode_reg_ff[dtc_pkg::MODE_HI],
                                       timer_mode_reg_ff[dtc_pkg::MODE_LO]});
  assign mode1 = dtc_pkg::dtc_mode_t'(
      {timer_mode_reg_ff[dtc_pkg::MODE_T1_BASE + dtc_pkg::MODE_HI],
       timer_mode_reg_ff[dtc_pkg::MODE_T1_BASE + dtc_pkg::MODE_LO]});
  logic t0_gate_select, t1_gate_select, src0, src1, en0, en1, inc0, inc1, inc0h;
  assign t0_gate_select = timer_mode_reg_ff[dtc_pkg::MODE_GATE];
  assign src0 = timer_mode_reg_ff[dtc_pkg::MODE_SRC];
  assign t1_gate_select = timer_mode_reg_ff[dtc_pkg::MODE_T1_BASE + dtc_pkg::MODE_GATE];
  assign src1 = timer_mode_reg_ff[dtc_pkg::MODE_T1_BASE + dtc_pkg::MODE_SRC];
  assign en0 = t0_run_bit_ff && (!t0_gate_select || sync2_ff[2]);
  assign en1 = t1_run_bit_ff && (!t1_gate_select || sync2_ff[3]);
  assign inc0 = en0 && (src0 ? fall0 : per_tick);
  assign inc1 = en1 && (src1 ? fall1 : per_tick) && (mode1 != dtc_pkg::DTC_MODE3);
  assign inc0h = t1_run_bit_ff && per_tick;
  // Register write decode
  assign wr_mode = reg_wr && reg_addr == dtc_pkg::ADDR_MODE;
  assign wr_ctrl = reg_wr && reg_addr == dtc_pkg::ADDR_CTRL;
  assign wr_t0l = reg_wr && reg_addr == dtc_pkg::ADDR_T0_LOW;
  assign wr_t0h = reg_wr && reg_addr == dtc_pkg::ADDR_T0_HIGH;
  assign wr_t1l = reg_wr && reg_addr == dtc_pkg::ADDR_T1_LOW;
  assign wr_t1h = reg_wr && reg_addr == dtc_pkg::ADDR_T1_HIGH;
  // Next count values and overflow events for one timer
  function automatic logic [16:0] step(input dtc_pkg::dtc_mode_t m, input logic [7:0] lo,
                                       input logic [7:0] hi, input logic inc);
    logic [7:0] nlo;
    logic [7:0] nhi;
    logic ovf;
    nlo = lo;
    nhi = hi;
    ovf = 1'b0;
    if (inc) begin
      unique case (m)
        dtc_pkg::DTC_MODE13: begin
          // Upper three low bits left as they are
          nlo = {lo[7:5], lo[4:0] + 5'h01};
          if (lo[4:0] == dtc_pkg::PRESCALE_LAST) begin
            nhi = hi + 8'h01;
            ovf = (hi == 8'hFF);
          end
        end
        dtc_pkg::DTC_MODE16: begin
          nlo = lo + 8'h01;
          if (lo == 8'hFF) begin
            nhi = hi + 8'h01;
            ovf = (hi == 8'hFF);
          end
        end
        dtc_pkg::DTC_MODE8R, dtc_pkg::DTC_MODE3: begin
          if (lo == 8'hFF) begin
            nlo = (m == dtc_pkg::DTC_MODE8R) ? hi : 8'h00;
            ovf = 1'b1;
          end else begin
            nlo = lo + 8'h01;
          end
        end
      endcase
    end
    return {ovf, nhi, nlo};
  endfunction
  logic [16:0] s0, s1;
  logic ovf0, ovf0h, ovf1;
  assign s0 = step(mode0, t0_low_count_ff, t0_high_count_ff, inc0);
  assign s1 = step(mode1, t1_low_count_ff, t1_high_count_ff, inc1);
  assign ovf0 = s0[16];
  assign ovf1 = s1[16];
  assign ovf0h = (mode0 == dtc_pkg::DTC_MODE3) && inc0h && t0_high_count_ff == 8'hFF;
  // Timer 0 counts
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      t0_low_count_ff <= dtc_pkg::RST_BYTE;
      t0_high_count_ff <= dtc_pkg::RST_BYTE;
    end else begin
      t0_low_count_ff <= wr_t0l ? reg_wdata : s0[7:0];
      if (wr_t0h) t0_high_count_ff <= reg_wdata;
      else if (mode0 == dtc_pkg::DTC_MODE3) begin
        if (inc0h) t0_high_count_ff <= t0_high_count_ff + 8'h01;
      end else t0_high_count_ff <= s0[15:8];
    end
  end
  // Timer 1 counts
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      t1_low_count_ff <= dtc_pkg::RST_BYTE;
      t1_high_count_ff <= dtc_pkg::RST_BYTE;
    end else begin
      t1_low_count_ff <= wr_t1l ? reg_wdata : s1[7:0];
      t1_high_count_ff <= wr_t1h ? reg_wdata : s1[15:8];
    end
  end
  // Mode and control bits
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timer_mode_reg_ff <= dtc_pkg::RST_BYTE;
      t0_run_bit_ff <= 1'b0;
      t1_run_bit_ff <= 1'b0;
      ext_irq_bits_ff <= dtc_pkg::RST_NIBBLE;
    end else begin
      if (wr_mode) timer_mode_reg_ff <= reg_wdata;
      if (wr_ctrl) begin
        t0_run_bit_ff <= reg_wdata[dtc_pkg::CTRL_T0_RUN];
        t1_run_bit_ff <= reg_wdata[dtc_pkg::CTRL_T1_RUN];
        ext_irq_bits_ff <= reg_wdata[3:0];
      end
    end
  end
  // Overflow flags: set beats hardware clear
  logic set0, set1;
  assign set0 = ovf0;
  assign set1 = (mode0 == dtc_pkg::DTC_MODE3) ? ovf0h : ovf1;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      t0_ovf_ff <= 1'b0;
      t1_ovf_ff <= 1'b0;
    end else begin
      if (set0) t0_ovf_ff <= 1'b1;
      else if (t0_irq_ack) t0_ovf_ff <= 1'b0;
      else if (wr_ctrl) t0_ovf_ff <= reg_wdata[dtc_pkg::CTRL_T0_OVF];
      if (set1) t1_ovf_ff <= 1'b1;
      else if (t1_irq_ack) t1_ovf_ff <= 1'b0;
      else if (wr_ctrl) t1_ovf_ff <= reg_wdata[dtc_pkg::CTRL_T1_OVF];
    end
  end
  // Sticky interrupt status and mask
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_stat_ff <= 2'h0;
      irq_mask_ff <= 2'h0;
    end else begin
      irq_stat_ff <= {set1, set0} |
          (irq_stat_ff & ~((reg_wr && reg_addr == dtc_pkg::ADDR_IRQ_STAT) ?
                           reg_wdata[1:0] : 2'h0));
      if (reg_wr && reg_addr == dtc_pkg::ADDR_IRQ_MASK) irq_mask_ff <= reg_wdata[1:0];
    end
  end
  // Outputs and read data
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      baud_tick_ff <= 1'b0;
      irq_ff <= 1'b0;
      reg_rdata_ff <= dtc_pkg::RST_BYTE;
    end else begin
      baud_tick_ff <= ovf1;
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
      reg_rdata_ff <= 8'h00;
      if (reg_rd) begin
        unique case (reg_addr)
          dtc_pkg::ADDR_MODE: reg_rdata_ff <= timer_mode_reg_ff;
          dtc_pkg::ADDR_CTRL: reg_rdata_ff <= {t1_ovf_ff, t1_run_bit_ff, t0_ovf_ff,
                                               t0_run_bit_ff, ext_irq_bits_ff};
          dtc_pkg::ADDR_T0_LOW: reg_rdata_ff <= t0_low_count_ff;
          dtc_pkg::ADDR_T0_HIGH: reg_rdata_ff <= t0_high_count_ff;
          dtc_pkg::ADDR_T1_LOW: reg_rdata_ff <= t1_low_count_ff;
          dtc_pkg::ADDR_T1_HIGH: reg_rdata_ff <= t1_high_count_ff;
          dtc_pkg::ADDR_IRQ_STAT: reg_rdata_ff <= {6'h00, irq_stat_ff};
          dtc_pkg::ADDR_IRQ_MASK: reg_rdata_ff <= {6'h00, irq_mask_ff};
        endcase
      end
    end
  end
  assign reg_rdata = reg_rdata_ff;
  assign t0_overflow_flag = t0_ovf_ff;
  assign t1_overflow_flag = t1_ovf_ff;
  assign baud_tick = baud_tick_ff;
  assign irq = irq_ff;
  // Assertions
  chk_ovf_sets_flag: assert property (@(posedge clk) disable iff (!rst_n)
    set0 |=> t0_overflow_flag) else $error("t0 flag not set on overflow");
  chk_t1_ovf_flag: assert property (@(posedge clk) disable iff (!rst_n)
    set1 |=> t1_overflow_flag)
    else $error("t1 flag not set on overflow");
  chk_set_beats_ack: assert property (@(posedge clk) disable iff (!rst_n)
    (set1 && t1_irq_ack) |=> t1_overflow_flag) else $error("t1 event lost");
  chk_ack_clears: assert property (@(posedge clk) disable iff (!rst_n)
    (t0_irq_ack && !set0) |=> !t0_overflow_flag) else $error("t0 flag not cleared");
  chk_t1_ack_clears: assert property (@(posedge clk) disable iff (!rst_n)
    (t1_irq_ack && !set1) |=> !t1_overflow_flag)
    else $error("t1 flag not cleared");
  chk_reload_high: assert property (@(posedge clk) disable iff (!rst_n)
    (mode0 == dtc_pkg::DTC_MODE8R && inc0 && t0_low_count_ff == 8'hFF && !wr_t0l)
    |=> t0_low_count_ff == $past(t0_high_count_ff)) else $error("no reload");
  chk_reload_keeps: assert property (@(posedge clk) disable iff (!rst_n)
    (mode0 == dtc_pkg::DTC_MODE8R && !wr_t0h) |=> $stable(t0_high_count_ff))
    else $error("reload byte changed");
  chk_t1_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (mode1 == dtc_pkg::DTC_MODE3 && !wr_t1l && !wr_t1h)
    |=> $stable(t1_low_count_ff) && $stable(t1_high_count_ff)) else $error("t1 moved");
  chk_split_idle: assert property (@(posedge clk) disable iff (!rst_n)
    (mode0 == dtc_pkg::DTC_MODE3 && !t1_run_bit_ff && !wr_t0h) |=> $stable(t0_high_count_ff))
    else $error("split high byte ran without t1 run");
  chk_tick_spacing: assert property (@(posedge clk) disable iff (!rst_n)
    per_tick |=> !per_tick [*5] ##1 per_tick) else $error("tick spacing");
  chk_gate_blocks: assert property (@(posedge clk) disable iff (!rst_n)
    (t1_gate_select && !sync2_ff[3] && !wr_t1l) |=> $stable(t1_low_count_ff))
    else $error("gated t1 counted");
  chk_t0_gate_select_blocks: assert property (@(posedge clk) disable iff (!rst_n)
    (t0_gate_select && !sync2_ff[2] && !wr_t0l) |=> $stable(t0_low_count_ff))
    else $error("gated t0 counted");
  chk_src_waits: assert property (@(posedge clk) disable iff (!rst_n)
    (src0 && !fall0 && !wr_t0l) |=> $stable(t0_low_count_ff))
    else $error("t0 counted without pin edge");
  chk_mode0_prescale: assert property (@(posedge clk) disable iff (!rst_n)
    (mode0 == dtc_pkg::DTC_MODE13 && inc0 && t0_low_count_ff[4:0] != 5'h1F && !wr_t0h)
    |=> $stable(t0_high_count_ff)) else $error("high byte early");
  chk_baud_follows: assert property (@(posedge clk) disable iff (!rst_n)
    ovf1 |=> baud_tick) else $error("baud tick missing");
  cov_t0_ovf: cover property (@(posedge clk) disable iff (!rst_n) set0);
  cov_t1_reload: cover property (@(posedge clk) disable iff (!rst_n)
    mode1 == dtc_pkg::DTC_MODE8R && ovf1);
  cov_split_high: cover property (@(posedge clk) disable iff (!rst_n) ovf0h);
  cov_irq: cover property (@(posedge clk) disable iff (!rst_n) irq);
  cov_gated_t1: cover property (@(posedge clk) disable iff (!rst_n)
    t1_gate_select && sync2_ff[3] && inc1);
endmodule
`default_nettype wire

// ---- dtc_pkg.sv ----
// Package with register map, field positions and timing constants of the dual timer
`default_nettype none
package dtc_pkg;
  localparam logic [2:0] ADDR_MODE = 3'h0;
  localparam logic [2:0] ADDR_CTRL = 3'h1;
  localparam logic [2:0] ADDR_T0_LOW = 3'h2;
  localparam logic [2:0] ADDR_T0_HIGH = 3'h3;
  localparam logic [2:0] ADDR_T1_LOW = 3'h4;
  localparam logic [2:0] ADDR_T1_HIGH = 3'h5;
  localparam logic [2:0] ADDR_IRQ_STAT = 3'h6;
  localparam logic [2:0] ADDR_IRQ_MASK = 3'h7;
  // Control register bit positions
  localparam int CTRL_T1_OVF = 7;
  localparam int CTRL_T1_RUN = 6;
  localparam int CTRL_T0_OVF = 5;
  localparam int CTRL_T0_RUN = 4;
  localparam int CTRL_IRQ1_FLAG = 3;
  localparam int CTRL_IRQ1_TYPE = 2;
  localparam int CTRL_IRQ0_FLAG = 1;
  localparam int CTRL_IRQ0_TYPE = 0;
  // Mode register: timer 1 in upper nibble, timer 0 in lower
  localparam int MODE_T1_BASE = 4;
  localparam int MODE_GATE = 3;
  localparam int MODE_SRC = 2;
  localparam int MODE_HI = 1;
  localparam int MODE_LO = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_NIBBLE = 4'h0;
  // Peripheral cycle of six clock periods
  localparam int PER_CLOCKS = 6;
  localparam logic [2:0] PER_LAST = 3'(PER_CLOCKS - 1);
  localparam logic [4:0] PRESCALE_LAST = 5'h1F;
  typedef enum logic [1:0] {
    DTC_MODE13,
    DTC_MODE16,
    DTC_MODE8R,
    DTC_MODE3
  } dtc_mode_t;
endpackage
`default_nettype wire

// ---- dtc_pin_model.sv ----
// Model of the external count inputs and gate pins
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model (
  // Clock
  input wire logic clk,
  // Pins
  output logic t0_count_pin,
  output logic t1_count_pin,
  output logic ext_irq0_pin,
  output logic ext_irq1_pin
);
  initial begin
    t0_count_pin = 1'b1;
    t1_count_pin = 1'b1;
    ext_irq0_pin = 1'b0;
    ext_irq1_pin = 1'b0;
  end
  // Each level held beyond one peripheral cycle
  task automatic pulse(input logic ch);
    @(posedge clk);
    if (ch) t1_count_pin <= 1'b0; else t0_count_pin <= 1'b0;
    repeat (8) @(posedge clk);
    if (ch) t1_count_pin <= 1'b1; else t0_count_pin <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task automatic gate(input logic ch, input logic lvl);
    @(posedge clk);
    if (ch) ext_irq1_pin <= lvl; else ext_irq0_pin <= lvl;
  endtask
endmodule
`default_nettype wire

// ---- test_dtc_timer.sv ----
// Testbench for the dual timer/counter
`timescale 1ns/1ps
`default_nettype none
module test_dtc_timer;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic t0_irq_ack = 1'b0;
  logic t1_irq_ack = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] v;
  logic t0_count_pin, t1_count_pin, ext_irq0_pin, ext_irq1_pin;
  logic t0_overflow_flag, t1_overflow_flag, baud_tick, irq;
  int baud_count = 0;
  int baud_base = 0;
  int mismatches = 0;
  int samples_checked = 0;
  always #25 clk = ~clk;
  // Count baud pulses where they are settled
  always @(negedge clk) if (baud_tick === 1'b1) baud_count <= baud_count + 1;
  dtc_timer i_dtc_timer (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .t0_irq_ack(t0_irq_ack), .t1_irq_ack(t1_irq_ack), .t0_count_pin(t0_count_pin),
    .t1_count_pin(t1_count_pin), .ext_irq0_pin(ext_irq0_pin), .ext_irq1_pin(ext_irq1_pin),
    .t0_overflow_flag(t0_overflow_flag), .t1_overflow_flag(t1_overflow_flag),
    .baud_tick(baud_tick), .irq(irq));
  dtc_pin_model i_dtc_pin_model (.clk(clk), .t0_count_pin(t0_count_pin),
    .t1_count_pin(t1_count_pin), .ext_irq0_pin(ext_irq0_pin), .ext_irq1_pin(ext_irq1_pin));
  task automatic stop_test();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp1(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  task automatic ack(input logic ch);
    @(posedge clk);
    if (ch) t1_irq_ack <= 1'b1; else t0_irq_ack <= 1'b1;
    @(posedge clk);
    t0_irq_ack <= 1'b0;
    t1_irq_ack <= 1'b0;
    @(negedge clk);
  endtask
  task automatic wait_hi(input logic ch, input int lim);
    int n;
    n = 0;
    while (n < lim) begin
      @(negedge clk);
      if ((ch ? t1_overflow_flag : t0_overflow_flag) === 1'b1) break;
      n++;
    end
    if (n >= lim) begin
      mismatches++;
      stop_test();
    end
  endtask
  task automatic load(input logic [7:0] m, input logic [2:0] a, input logic [7:0] lo);
    wr(dtc_pkg::ADDR_CTRL, 8'h00);
    wr(dtc_pkg::ADDR_MODE, m);
    wr(a, lo);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(dtc_pkg::ADDR_MODE, v);
    cmp8("mode reset", dtc_pkg::RST_BYTE, v);
    // Mode 1: 16-bit wrap, flag, ack, status and mask
    load(8'h01, dtc_pkg::ADDR_T0_LOW, 8'hFF);
    wr(dtc_pkg::ADDR_T0_HIGH, 8'hFF);
    wr(dtc_pkg::ADDR_CTRL, 8'h10);
    wait_hi(1'b0, 40);
    wr(dtc_pkg::ADDR_CTRL, 8'h20);
    rd(dtc_pkg::ADDR_T0_HIGH, v);
    cmp8("t0 high", 8'h00, v);
    ack(1'b0);
    cmp1("t0 flag", 1'b0, t0_overflow_flag);
    rd(dtc_pkg::ADDR_IRQ_STAT, v);
    cmp8("status", 8'h01, v);
    wr(dtc_pkg::ADDR_IRQ_MASK, 8'h01);
    repeat (2) @(negedge clk);
    cmp1("irq", 1'b1, irq);
    wr(dtc_pkg::ADDR_IRQ_STAT, 8'h01);
    repeat (2) @(negedge clk);
    cmp1("irq", 1'b0, irq);
    // Mode 2: reload, then reload value changed while running
    load(8'h02, dtc_pkg::ADDR_T0_LOW, 8'hFE);
    wr(dtc_pkg::ADDR_T0_HIGH, 8'hF0);
    wr(dtc_pkg::ADDR_CTRL, 8'h10);
    wait_hi(1'b0, 40);
    rd(dtc_pkg::ADDR_T0_LOW, v);
    cmp8("t0 low", 8'hF0, v);
    ack(1'b0);
    wr(dtc_pkg::ADDR_T0_HIGH, 8'h80);
    wait_hi(1'b0, 1000);
    rd(dtc_pkg::ADDR_T0_LOW, v);
    cmp8("t0 low", 8'h80, v);
    // Mode 0 on both timers: prescaler wrap into high byte, baud pulse
    load(8'h00, dtc_pkg::ADDR_T1_LOW, 8'h1F);
    wr(dtc_pkg::ADDR_T1_HIGH, 8'hFF);
    wr(dtc_pkg::ADDR_T0_LOW, 8'hFE);
    wr(dtc_pkg::ADDR_T0_HIGH, 8'h7F);
    baud_base = baud_count;
    wr(dtc_pkg::ADDR_CTRL, 8'h50);
    wait_hi(1'b1, 40);
    wr(dtc_pkg::ADDR_CTRL, 8'h80);
    rd(dtc_pkg::ADDR_T1_HIGH, v);
    cmp8("t1 high", 8'h00, v);
    rd(dtc_pkg::ADDR_T1_LOW, v);
    cmp8("t1 low", 8'h00, v & 8'h1F);
    rd(dtc_pkg::ADDR_T0_HIGH, v);
    cmp8("t0 high", 8'h7F, v);
    rd(dtc_pkg::ADDR_T0_LOW, v);
    cmp8("t0 low", 8'h1F, v & 8'h1F);
    cmp8("baud", 8'h01, 8'(baud_count - baud_base));
    ack(1'b1);
    cmp1("t1 flag", 1'b0, t1_overflow_flag);
    // Gated timers wait for their pins
    load(8'h99, dtc_pkg::ADDR_T1_LOW, 8'hFF);
    wr(dtc_pkg::ADDR_T1_HIGH, 8'hFF);
    wr(dtc_pkg::ADDR_T0_LOW, 8'hFF);
    wr(dtc_pkg::ADDR_T0_HIGH, 8'hFF);
    wr(dtc_pkg::ADDR_CTRL, 8'h50);
    repeat (30) @(negedge clk);
    cmp1("t0 flag", 1'b0, t0_overflow_flag);
    cmp1("t1 flag", 1'b0, t1_overflow_flag);
    i_dtc_pin_model.gate(1'b0, 1'b1);
    wait_hi(1'b0, 40);
    cmp1("t1 flag", 1'b0, t1_overflow_flag);
    i_dtc_pin_model.gate(1'b1, 1'b1);
    wait_hi(1'b1, 40);
    i_dtc_pin_model.gate(1'b1, 1'b0);
    i_dtc_pin_model.gate(1'b0, 1'b0);
    // Counter sources: one count per falling edge, timer 1 reloading
    load(8'h65, dtc_pkg::ADDR_T0_LOW, 8'hFE);
    wr(dtc_pkg::ADDR_T0_HIGH, 8'hFF);
    wr(dtc_pkg::ADDR_T1_LOW, 8'hFF);
    wr(dtc_pkg::ADDR_T1_HIGH, 8'h40);
    wr(dtc_pkg::ADDR_CTRL, 8'h50);
    i_dtc_pin_model.pulse(1'b0);
    rd(dtc_pkg::ADDR_T0_LOW, v);
    cmp8("t0 low", 8'hFF, v);
    rd(dtc_pkg::ADDR_T1_LOW, v);
    cmp8("t1 low", 8'hFF, v);
    cmp1("t0 flag", 1'b0, t0_overflow_flag);
    i_dtc_pin_model.pulse(1'b1);
    rd(dtc_pkg::ADDR_T1_LOW, v);
    cmp8("t1 low", 8'h40, v);
    cmp1("t1 flag", 1'b1, t1_overflow_flag);
    i_dtc_pin_model.pulse(1'b0);
    @(negedge clk);
    cmp1("t0 flag", 1'b1, t0_overflow_flag);
    // Split timer 0 with timer 1 halted, service held through the wrap
    load(8'h33, dtc_pkg::ADDR_T1_LOW, 8'h55);
    wr(dtc_pkg::ADDR_T0_LOW, 8'hFF);
    wr(dtc_pkg::ADDR_T0_HIGH, 8'hFF);
    t1_irq_ack <= 1'b1;
    wr(dtc_pkg::ADDR_CTRL, 8'h50);
    wait_hi(1'b1, 40);
    @(posedge clk);
    t1_irq_ack <= 1'b0;
    wait_hi(1'b0, 40);
    cmp1("t1 flag", 1'b0, t1_overflow_flag);
    rd(dtc_pkg::ADDR_T1_LOW, v);
    cmp8("t1 low", 8'h55, v);
    stop_test();
  end
endmodule
`default_nettype wire
